// ---- swgl_defines.svh ----
// Timing constants and frame layout for the single-wire gauge link.
// Assumes a 20 MHz system clock; every count is derived from a time in ns.
`ifndef SWGL_DEFINES_SVH
`define SWGL_DEFINES_SVH

// ==========================================================================
// Clock
// ==========================================================================
`define SWGL_CLK_PERIOD_NS 50

// ==========================================================================
// Link times in ns as printed, then cycle counts (least up, longest down)
// ==========================================================================
`define SWGL_BREAK_NS 190000
`define SWGL_BREAK_CYC ((`SWGL_BREAK_NS + `SWGL_CLK_PERIOD_NS - 1) / `SWGL_CLK_PERIOD_NS)
`define SWGL_SAMPLE_NS 68000
`define SWGL_SAMPLE_CYC (`SWGL_SAMPLE_NS / `SWGL_CLK_PERIOD_NS)
`define SWGL_RSP_MIN_NS 190000
`define SWGL_RSP_NS 250000
`define SWGL_RSP_CYC ((`SWGL_RSP_NS + `SWGL_CLK_PERIOD_NS - 1) / `SWGL_CLK_PERIOD_NS)
`define SWGL_DBIT_NS 220000
`define SWGL_DBIT_CYC ((`SWGL_DBIT_NS + `SWGL_CLK_PERIOD_NS - 1) / `SWGL_CLK_PERIOD_NS)
`define SWGL_DONE_NS 40000
`define SWGL_DONE_CYC ((`SWGL_DONE_NS + `SWGL_CLK_PERIOD_NS - 1) / `SWGL_CLK_PERIOD_NS)
`define SWGL_DZERO_NS 110000
`define SWGL_DZERO_CYC ((`SWGL_DZERO_NS + `SWGL_CLK_PERIOD_NS - 1) / `SWGL_CLK_PERIOD_NS)
`define SWGL_SLEEP_NS 2000000

// ==========================================================================
// Frame layout
// ==========================================================================
`define SWGL_BITS 8
`define SWGL_ADDR_W 7
`define SWGL_RW_BIT 7
`define SWGL_CNT_W 16
`define SWGL_BIT_W 4
`define SWGL_ZERO16 16'h0000
`define SWGL_ONE16 16'h0001
`define SWGL_ZERO4 4'h0
`define SWGL_ONE4 4'h1
`endif

// ---- swgl_fifo_if.sv ----
// Carrier between the link engine and its response FIFO.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
interface swgl_fifo_if #(parameter int WIDTH = 8);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
    modport user (output in_valid, output in_data, input in_ready,
                  input out_valid, input out_data, output out_ready);
endinterface

// ---- swgl_fifo.sv ----
// Response FIFO: read data waits here until the link engine sends it.
// Assumes a single clock; reset empties it.
`timescale 1ns/100ps
module swgl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    swgl_fifo_if.fifo f // Both sides of the queue.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic full, empty;

    assign empty = (wr_reg == rd_reg);
    assign full = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
    assign f.in_ready = !full;
    assign f.out_valid = !empty;
    assign f.out_data = mem[rd_reg[AW-1:0]];

    always_comb begin
        wr_next = wr_reg + (AW+1)'(f.in_valid && !full);
        rd_next = rd_reg + (AW+1)'(f.out_ready && !empty);
    end

    always_ff @(posedge clk) begin
        if (f.in_valid && !full) begin
            mem[wr_reg[AW-1:0]] <= f.in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end
endmodule

// ---- swgl_link.sv ----
// Device end of the single-wire gauge link: decodes host bits, answers reads.
// Assumes the serial line input is already synchronous to clk and pulled high idle.
// Summary of operation
// [RULE_01] Host break: long low then release.
// [RULE_02] Host bit window; zero is long low.
// [RULE_03] Host one is a short low pulse.
// [RULE_04] First reply bit 190 to 320 us later.
// [RULE_05] Device bit window 190 to 260 us.
// [RULE_06] Device one: low 32 to 50 us.
// [RULE_07] Device zero: low 80 to 145 us.
// [RULE_08] Line held low enters sleep mode.
// [RULE_09] About five kilobits per second each way.
// [RULE_10] Eight-bit command LSB first; read returns byte.
// [RULE_11] Pull low only; sample mid window.
`timescale 1ns/100ps
`include "swgl_defines.svh"

// ==========================================================================
// Types
// ==========================================================================
package swgl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BREAK,
        ST_RECOVER,
        ST_RXWAIT,
        ST_RXBIT,
        ST_RESP,
        ST_TXBIT
    } swgl_state_t;
endpackage

module swgl_link import swgl_pkg::*; #(
    parameter int SLEEP_CYC = `SWGL_SLEEP_NS / `SWGL_CLK_PERIOD_NS,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk, // System clock, 20 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic serial_line_in, // Level seen on the serial line.
    output logic serial_line_out, // Driven level, always low.
    output logic serial_line_oe, // High while pulling the line low.
    output logic cmd_valid, // One-cycle pulse: command received.
    output logic [6:0] cmd_addr, // Register address of the command.
    output logic cmd_write, // Command is a write.
    output logic wr_valid, // One-cycle pulse: write data received.
    output logic [7:0] wr_data, // Write data byte.
    input wire logic rd_valid, // Read data offered.
    input wire logic [7:0] rd_data, // Read data byte.
    output logic rd_ready, // FIFO accepts read data.
    output logic sleep // Line held low; low-power mode.
);

    swgl_fifo_if #(.WIDTH(`SWGL_BITS)) q ();
    swgl_fifo #(.WIDTH(`SWGL_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .f(q.fifo)
    );

    // ======================================================================
    // Next-state logic
    // ======================================================================
    swgl_state_t st_reg, st_next;
    logic [`SWGL_CNT_W-1:0] cnt_reg, cnt_next;
    logic [31:0] low_reg, low_next;
    logic [`SWGL_BIT_W-1:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic prev_reg, prev_next, write_reg, write_next, oe_reg, oe_next;
    logic cv_reg, cv_next, wv_reg, wv_next, slp_reg, slp_next;
    logic [6:0] addr_reg, addr_next;
    logic fall;

    assign fall = prev_reg && !serial_line_in;
    assign q.in_valid = rd_valid;
    assign q.in_data = rd_data;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg + `SWGL_ONE16;
        bit_next = bit_reg;
        sh_next = sh_reg;
        prev_next = serial_line_in;
        write_next = write_reg;
        addr_next = addr_reg;
        oe_next = 1'b0;
        cv_next = 1'b0;
        wv_next = 1'b0;
        q.out_ready = 1'b0;
        // Count low time for sleep; any high level wakes the link.
        // The count saturates so that a long sleep never wraps back to awake.
        low_next = serial_line_in ? 32'h0000_0000
                 : (low_reg >= 32'(SLEEP_CYC)) ? low_reg : low_reg + 32'h0000_0001; // RULE_08
        slp_next = !serial_line_in && (low_reg >= 32'(SLEEP_CYC)); // RULE_08
        unique case (st_reg)
            ST_IDLE: begin
                cnt_next = `SWGL_ZERO16;
                if (!serial_line_in) begin
                    st_next = ST_BREAK;
                end
            end
            ST_BREAK: begin
                // A break is a low at least as long as its minimum.
                if (serial_line_in) begin
                    st_next = (cnt_reg >= 16'(`SWGL_BREAK_CYC)) ? ST_RECOVER : ST_IDLE; // RULE_01
                    bit_next = `SWGL_ZERO4;
                end
            end
            ST_RECOVER, ST_RXWAIT: begin
                cnt_next = `SWGL_ZERO16;
                if (fall) begin
                    st_next = ST_RXBIT;
                    cnt_next = `SWGL_ONE16;
                end
            end
            ST_RXBIT: begin
                // Sample between a one's pulse end and a zero's pulse end.
                if (cnt_reg == 16'(`SWGL_SAMPLE_CYC)) begin // RULE_11
                    sh_next = {serial_line_in, sh_reg[7:1]}; // RULE_02 RULE_03 RULE_10
                    bit_next = bit_reg + `SWGL_ONE4;
                end else if (cnt_reg > 16'(`SWGL_SAMPLE_CYC) && serial_line_in) begin
                    if (bit_reg == 4'(`SWGL_BITS)) begin
                        bit_next = `SWGL_ZERO4;
                        cnt_next = `SWGL_ZERO16;
                        st_next = ST_RXWAIT;
                    end else begin
                        st_next = ST_RXWAIT;
                    end
                end
                if (st_next == ST_RXWAIT && bit_reg == 4'(`SWGL_BITS)) begin
                    if (write_reg) begin
                        wv_next = 1'b1;
                        write_next = 1'b0;
                        st_next = ST_IDLE;
                    end else begin
                        cv_next = 1'b1;
                        addr_next = sh_reg[`SWGL_ADDR_W-1:0];
                        write_next = sh_reg[`SWGL_RW_BIT];
                        st_next = sh_reg[`SWGL_RW_BIT] ? ST_RXWAIT : ST_RESP; // RULE_10
                    end
                end
            end
            ST_RESP: begin
                // Response delay counted from the release after the last bit.
                if (cnt_reg >= 16'(`SWGL_RSP_CYC) && q.out_valid) begin // RULE_04
                    sh_next = q.out_data;
                    q.out_ready = 1'b1;
                    cnt_next = `SWGL_ZERO16;
                    st_next = ST_TXBIT;
                end else if (cnt_reg >= 16'(`SWGL_RSP_CYC)) begin
                    cnt_next = cnt_reg;
                end
            end
            ST_TXBIT: begin
                oe_next = sh_reg[0] ? (cnt_reg < 16'(`SWGL_DONE_CYC) - 16'h0001) // RULE_06
                                    : (cnt_reg < 16'(`SWGL_DZERO_CYC) - 16'h0001); // RULE_07 RULE_11
                if (cnt_reg == 16'(`SWGL_DBIT_CYC) - 16'h0001) begin // RULE_05 RULE_09
                    cnt_next = `SWGL_ZERO16;
                    sh_next = {1'b0, sh_reg[7:1]};
                    bit_next = bit_reg + `SWGL_ONE4;
                    oe_next = 1'b1;
                    if (bit_reg == 4'(`SWGL_BITS) - `SWGL_ONE4) begin
                        bit_next = `SWGL_ZERO4;
                        oe_next = 1'b0;
                        st_next = ST_IDLE;
                    end
                end
            end
            default: st_next = ST_IDLE;
        endcase
        if (slp_reg && !serial_line_in) begin
            st_next = ST_IDLE; // RULE_08
            oe_next = 1'b0;
        end
    end

    // ======================================================================
    // State registers
    // ======================================================================
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_IDLE;
            cnt_reg <= `SWGL_ZERO16;
            low_reg <= 32'h0000_0000;
            bit_reg <= `SWGL_ZERO4;
            sh_reg <= 8'h00;
            prev_reg <= 1'b0;
            write_reg <= 1'b0;
            addr_reg <= 7'h00;
            oe_reg <= 1'b0;
            cv_reg <= 1'b0;
            wv_reg <= 1'b0;
            slp_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            low_reg <= low_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            prev_reg <= prev_next;
            write_reg <= write_next;
            addr_reg <= addr_next;
            oe_reg <= oe_next;
            cv_reg <= cv_next;
            wv_reg <= wv_next;
            slp_reg <= slp_next;
        end
    end

    // The line is open drain: only low is ever driven.
    assign serial_line_out = 1'b0; // RULE_11
    assign serial_line_oe = oe_reg;
    assign cmd_valid = cv_reg;
    assign cmd_addr = addr_reg;
    assign cmd_write = write_reg;
    assign wr_valid = wv_reg;
    assign wr_data = sh_reg;
    assign rd_ready = q.in_ready;
    assign sleep = slp_reg;

    // ======================================================================
    // Checks
    // ======================================================================
    int oe_run;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oe_run <= 0;
        end else begin
            oe_run <= oe_reg ? oe_run + 1 : 0;
        end
    end

    // Cycles since the start of the last reply bit; zero outside a reply.
    int win_cnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_cnt <= 0;
        end else if (oe_reg && oe_run == 0) begin
            win_cnt <= 1;
        end else if (win_cnt != 0 && st_reg == ST_TXBIT) begin
            win_cnt <= win_cnt + 1;
        end else begin
            win_cnt <= 0;
        end
    end

    sequence s_pulse_end;
        $fell(oe_reg);
    endsequence

    sequence s_next_bit;
        oe_reg && oe_run == 0 && win_cnt != 0;
    endsequence

    AST_ZERO_MAX: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
        oe_run <= 2900) else $error("device low pulse longer than 145 us");
    AST_ONE_MIN: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
        s_pulse_end |-> $past(oe_run) >= 640) else $error("device low pulse under 32 us");
    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
        serial_line_oe |-> serial_line_out == 1'b0 && $past(st_reg) == ST_TXBIT)
        else $error("line driven outside a reply");
    AST_WINDOW: assert property (@(posedge clk) disable iff (!resetn) // RULE_05 RULE_09
        s_next_bit |-> win_cnt >= 3800 && win_cnt <= 5200)
        else $error("device bit window out of range");
    AST_RESP_DELAY: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
        st_reg == ST_RESP && cnt_reg < 16'(`SWGL_RSP_CYC) |-> !oe_reg)
        else $error("response started too early");
    AST_SLEEP: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        serial_line_in |=> !sleep) else $error("sleep while line high");
    AST_CMD_PULSE: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
        cmd_valid |=> !cmd_valid) else $error("command strobe longer than one cycle");
    AST_SLEEP_RELEASE: assert property (@(posedge clk) disable iff (!resetn) // RULE_08
        sleep && !serial_line_in |=> !oe_reg) else $error("driving line while asleep");
endmodule

// ---- swgl_host_model.sv ----
// Host side of the single-wire gauge link: sends breaks and bits, times replies.
// Assumes the bench resolves the wire and feeds the level back on line.
`timescale 1ns/100ps
module swgl_host_model (
    input wire logic clk, // System clock.
    input wire logic line, // Resolved wire level.
    output logic host_low, // High while the host pulls the wire low.
    output logic rx_done, // One-cycle pulse: reply byte taken.
    output logic [7:0] rx_byte // Reply byte, LSB first on the wire.
);
    int rsp;
    int lo_w[8];
    int win_w[8];

    initial begin
        host_low = 1'b0;
        rx_done = 1'b0;
        rx_byte = 8'h00;
    end

    // ======================================================================
    // Transmit
    // ======================================================================
    task automatic send_break();
        @(posedge clk) host_low <= 1'b1;
        repeat (3900) @(posedge clk);
        host_low <= 1'b0;
        repeat (900) @(posedge clk);
    endtask

    // The last bit returns at its rise so the reply delay is timed from there.
    task automatic send_byte(input logic [7:0] v, input int slack);
        for (int i = 0; i < 8; i++) begin
            host_low <= 1'b1;
            repeat (v[i] ? 400 : 2200) @(posedge clk);
            host_low <= 1'b0;
            if (i < 7) begin
                repeat ((v[i] ? 3400 : 1600) + slack) @(posedge clk);
            end
        end
    endtask

    // Holds the wire low for a number of cycles, as a detached host would.
    task automatic hold_low(input int cycles);
        @(posedge clk) host_low <= 1'b1;
        repeat (cycles) @(posedge clk);
        host_low <= 1'b0;
    endtask

    // ======================================================================
    // Receive
    // ======================================================================
    task automatic recv_byte();
        int n;
        logic [7:0] v;
        n = 0;
        // Let the release of the last command bit reach the wire first.
        @(posedge clk);
        while (line === 1'b1 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        rsp = n;
        for (int i = 0; i < 8; i++) begin
            n = 0;
            while (line === 1'b0 && n < 4000) begin
                @(posedge clk);
                n++;
            end
            lo_w[i] = n;
            v[i] = (n < 1300);
            while (i < 7 && line === 1'b1 && n < 7000) begin
                @(posedge clk);
                n++;
            end
            win_w[i] = n;
        end
        rx_byte <= v;
        rx_done <= 1'b1;
        @(posedge clk) rx_done <= 1'b0;
    endtask
endmodule

// ---- tb_single_wire_gauge_link.sv ----
// Self-checking bench for the device end of the single-wire gauge link.
// Assumes swgl_link, its FIFO and the host model are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_single_wire_gauge_link;
    logic clk, resetn, rd_valid, rd_ready, host_low, rx_done, line;
    logic serial_line_out, serial_line_oe, cmd_valid, cmd_write, wr_valid, sleep;
    logic [6:0] cmd_addr;
    logic [7:0] rd_data, wr_data, rx_byte, first_data;
    logic [31:0] seed = 32'h76f7ae49;
    logic [7:0] exp_q[$];
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    // Longer than any legal low on the wire, so sleep never cuts a frame short.
    localparam int SLEEP_TB = 5000;

    // The host side idles high; either party may pull low.
    assign line = (serial_line_oe ? serial_line_out : 1'b1) & ~host_low;

    swgl_link #(.SLEEP_CYC(SLEEP_TB)) uut (.clk(clk), .resetn(resetn), .serial_line_in(line),
        .serial_line_out(serial_line_out), .serial_line_oe(serial_line_oe),
        .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_write(cmd_write),
        .wr_valid(wr_valid), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_ready(rd_ready), .sleep(sleep));
    swgl_host_model host (.clk(clk), .line(line), .host_low(host_low), .rx_done(rx_done),
        .rx_byte(rx_byte));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ======================================================================
    // Clock, timeout and result monitor
    // ======================================================================
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            failures++;
            finish_test();
        end
    end

    // A read must never report write data.
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) begin
            `CHK({cmd_write, cmd_addr}, exp_q.pop_front())
        end
        if (rx_done === 1'b1) begin
            `CHK(rx_byte, exp_q.pop_front())
        end
        if (wr_valid === 1'b1) begin
            `CHK(wr_valid, 1'b0)
        end
    end

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        logic [6:0] addr;
        logic [7:0] b;
        resetn = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            b = 8'(rnd());
            rd_valid <= 1'b1;
            rd_data <= b;
            if (i == 0) begin
                first_data = b;
            end
        end
        @(posedge clk) rd_valid <= 1'b0;
        @(posedge clk);
        `CHK(rd_ready, 1'b0)
        rd_valid <= 1'b1;
        rd_data <= 8'h5a;
        @(posedge clk) rd_valid <= 1'b0;
        $display("fifo fill test done");

        addr = 7'(rnd());
        exp_q.push_back({1'b0, addr});
        exp_q.push_back(first_data);
        host.send_break();
        host.send_byte({1'b0, addr}, rnd() % 200);
        host.recv_byte();
        `CHK(host.rsp >= 3800 && host.rsp <= 6400, 1'b1)
        for (int i = 0; i < 8; i++) begin
            if (rx_byte[i]) begin
                `CHK(host.lo_w[i] >= 640 && host.lo_w[i] <= 1000, 1'b1)
            end else begin
                `CHK(host.lo_w[i] >= 1600 && host.lo_w[i] <= 2900, 1'b1)
            end
            if (i < 7) begin
                `CHK(host.win_w[i] >= 3800 && host.win_w[i] <= 5200, 1'b1)
            end
        end
        @(posedge clk);
        `CHK(exp_q.size(), 0)
        `CHK(rd_ready, 1'b1)
        $display("read transaction test done");

        host.hold_low(SLEEP_TB + 20);
        `CHK(sleep, 1'b1)
        repeat (2) @(posedge clk);
        `CHK(sleep, 1'b0)
        $display("sleep entry test done");
        finish_test();
    end
endmodule
